// ===== eep_consts.vh
// Constants for the serial EEPROM two-wire slave
`ifndef EEP_CONSTS_VH
`define EEP_CONSTS_VH
// Control byte type code and field positions
`define EEP_TYPE_CODE    4'ha
`define EEP_TYPE_MSB     7
`define EEP_TYPE_LSB     4
`define EEP_SEL_MSB      3
`define EEP_SEL_LSB      1
`define EEP_RW_BIT       0
// Array and page geometry
`define EEP_MEM_BYTES    256
`define EEP_PAGE_BYTES   8
// Bits per byte before the acknowledge slot
`define EEP_BYTE_BITS    4'h8
// Program cycle time and clock rate
`define EEP_TWR_MS       10
`define EEP_CLK_KHZ      10000
`define EEP_TWR_CYCLES   (`EEP_TWR_MS * `EEP_CLK_KHZ)
// Reset values
`define EEP_PTR_RST      8'h00
`define EEP_CNT_RST      4'h0
`define EEP_SHIFT_RST    8'h00
`define EEP_PAGE_RST     5'h00
`define EEP_VALID_RST    8'h00
`define EEP_TMR_RST      17'h00000
`endif

// ===== eep_slave.v
// Two-wire serial EEPROM slave with hardware write protect
`timescale 1ns/10ps
`include "eep_consts.vh"
module eep_slave #(
  parameter WRITE_CYCLES = `EEP_TWR_CYCLES
) (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       nrst,
  // Two-wire link
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  // Straps and protect
  input  wire       chip_select_bit0,
  input  wire       chip_select_bit1,
  input  wire       chip_select_bit2,
  input  wire       write_protect,
  // Status
  output wire       prog_busy
);
  // One-hot states
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_CTRL = 7'h02;
  localparam [6:0] ST_WADR = 7'h04;
  localparam [6:0] ST_WDAT = 7'h08;
  localparam [6:0] ST_ACK  = 7'h10;
  localparam [6:0] ST_RDAT = 7'h20;
  localparam [6:0] ST_MACK = 7'h40;

  reg  [2:0]  scl_sync_reg;
  reg  [2:0]  sda_sync_reg;
  reg  [2:0]  wp_sync_reg;
  reg         scl_f_reg;
  reg         sda_f_reg;
  reg         wp_f_reg;
  reg         scl_prev_reg;
  reg         sda_prev_reg;
  reg  [6:0]  state_reg;
  reg  [6:0]  after_reg;
  reg  [3:0]  cnt_reg;
  reg  [7:0]  shift_reg;
  reg  [7:0]  ptr_reg;
  reg  [4:0]  page_reg;
  reg  [7:0]  valid_reg;
  reg         pend_reg;
  reg         busy_reg;
  reg  [16:0] tmr_reg;
  reg         oe_reg;
  reg         out_reg;
  reg  [7:0]  mem [0:`EEP_MEM_BYTES-1];
  reg  [7:0]  pbuf [0:`EEP_PAGE_BYTES-1];
  integer     i;

  wire        scl_rise;
  wire        scl_fall;
  wire        start_det;
  wire        stop_det;
  wire        byte_done;
  wire        addr_hit;
  wire        data_take;
  wire        commit;

  // Three-stage sampling; a level counts once stages two and three agree
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      wp_sync_reg  <= 3'h0;
      scl_f_reg    <= 1'b1;
      sda_f_reg    <= 1'b1;
      wp_f_reg     <= 1'b0;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      wp_sync_reg  <= {wp_sync_reg[1:0], write_protect};
      if (scl_sync_reg[1] == scl_sync_reg[2])
        scl_f_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2])
        sda_f_reg <= sda_sync_reg[2];
      if (wp_sync_reg[1] == wp_sync_reg[2])
        wp_f_reg <= wp_sync_reg[2];
      scl_prev_reg <= scl_f_reg;
      sda_prev_reg <= sda_f_reg;
    end
  end

  // Link events: serial clock edges, and data edges while the clock is high
  assign scl_rise  = scl_f_reg & ~scl_prev_reg;
  assign scl_fall  = ~scl_f_reg & scl_prev_reg;
  assign start_det = scl_f_reg & scl_prev_reg & sda_prev_reg & ~sda_f_reg;
  assign stop_det  = scl_f_reg & scl_prev_reg & ~sda_prev_reg & sda_f_reg;
  assign byte_done = scl_fall & (cnt_reg == `EEP_BYTE_BITS) &
                     ((state_reg == ST_CTRL) | (state_reg == ST_WADR) | (state_reg == ST_WDAT));
  // Type code and all three selects must match, and no program running
  assign addr_hit  = (shift_reg[`EEP_TYPE_MSB:`EEP_TYPE_LSB] == `EEP_TYPE_CODE) &
                     (shift_reg[`EEP_SEL_MSB:`EEP_SEL_LSB] ==
                      {chip_select_bit2, chip_select_bit1, chip_select_bit0}) &
                     ~busy_reg;
  // Data byte accepted only when unprotected
  assign data_take = byte_done & (state_reg == ST_WDAT) & ~wp_f_reg;
  assign commit    = busy_reg & (tmr_reg == 17'h00000);

  // Page buffer and array storage; no reset, contents are data only
  always @(posedge sys_clk)
  begin
    if (data_take)
      pbuf[ptr_reg[2:0]] <= shift_reg;
    if (commit)
      for (i = 0; i < `EEP_PAGE_BYTES; i = i + 1)
        if (valid_reg[i])
          mem[{page_reg, i[2:0]}] <= pbuf[i];
  end

  // Protocol engine, pointer and program timer
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= ST_IDLE;
      after_reg <= ST_IDLE;
      cnt_reg   <= `EEP_CNT_RST;
      shift_reg <= `EEP_SHIFT_RST;
      ptr_reg   <= `EEP_PTR_RST;
      page_reg  <= `EEP_PAGE_RST;
      valid_reg <= `EEP_VALID_RST;
      pend_reg  <= 1'b0;
      busy_reg  <= 1'b0;
      tmr_reg   <= `EEP_TMR_RST;
      oe_reg    <= 1'b0;
      out_reg   <= 1'b0;
    end
    else
    begin
      // Self-timed program cycle, erase folded into the final write
      if (busy_reg && tmr_reg != 17'h00000)
        tmr_reg <= tmr_reg - 17'h00001;
      if (commit)
        busy_reg <= 1'b0;
      if (start_det)
      begin
        // Repeated start drops any unfinished page
        state_reg <= ST_CTRL;
        cnt_reg   <= `EEP_CNT_RST;
        oe_reg    <= 1'b0;
        pend_reg  <= 1'b0;
      end
      else if (stop_det)
      begin
        state_reg <= ST_IDLE;
        oe_reg    <= 1'b0;
        pend_reg  <= 1'b0;
        // Program only with accepted bytes and protect still low
        if (pend_reg && !wp_f_reg)
        begin
          busy_reg <= 1'b1;
          tmr_reg  <= WRITE_CYCLES[16:0] - 17'h00001;
        end
      end
      else if (scl_rise)
      begin
        case (state_reg)
          ST_CTRL, ST_WADR, ST_WDAT, ST_RDAT:
          begin
            if (state_reg != ST_RDAT)
              shift_reg <= {shift_reg[6:0], sda_f_reg};
            cnt_reg <= cnt_reg + 4'h1;
          end
          ST_MACK:
          begin
            // Master nack ends the read; line stays released
            if (sda_f_reg)
              state_reg <= ST_IDLE;
            else
              cnt_reg <= `EEP_CNT_RST;
          end
          default:
          begin
            cnt_reg <= cnt_reg;
          end
        endcase
      end
      else if (byte_done)
      begin
        state_reg <= ST_ACK;
        case (state_reg)
          ST_CTRL:
          begin
            oe_reg    <= addr_hit;
            after_reg <= !addr_hit ? ST_IDLE :
                         (shift_reg[`EEP_RW_BIT] ? ST_RDAT : ST_WADR);
          end
          ST_WADR:
          begin
            // Word address acked even when protected
            oe_reg    <= 1'b1;
            after_reg <= ST_WDAT;
            ptr_reg   <= shift_reg;
            page_reg  <= shift_reg[7:3];
            valid_reg <= 8'h00;
          end
          default:
          begin
            // Protected data gets no ack and the rest is ignored
            oe_reg    <= ~wp_f_reg;
            after_reg <= wp_f_reg ? ST_IDLE : ST_WDAT;
            if (!wp_f_reg)
            begin
              valid_reg[ptr_reg[2:0]] <= 1'b1;
              pend_reg                <= 1'b1;
              // Wrap inside the page, later bytes overwrite
              ptr_reg <= {ptr_reg[7:3], ptr_reg[2:0] + 3'h1};
            end
          end
        endcase
      end
      else if (scl_fall)
      begin
        case (state_reg)
          ST_ACK, ST_MACK:
          begin
            if (state_reg == ST_ACK)
              state_reg <= after_reg;
            cnt_reg <= `EEP_CNT_RST;
            if ((state_reg == ST_ACK && after_reg == ST_RDAT) ||
                (state_reg == ST_MACK && cnt_reg == `EEP_CNT_RST))
            begin
              // Load next byte and present its top bit
              state_reg <= ST_RDAT;
              shift_reg <= mem[ptr_reg];
              oe_reg    <= ~mem[ptr_reg][7];
              ptr_reg   <= ptr_reg + 8'h01;
            end
            else
              oe_reg <= 1'b0;
          end
          ST_RDAT:
          begin
            if (cnt_reg == `EEP_BYTE_BITS)
            begin
              // Release for the master's acknowledge slot
              state_reg <= ST_MACK;
              oe_reg    <= 1'b0;
            end
            else
            begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              oe_reg    <= ~shift_reg[6];
            end
          end
          default:
          begin
            oe_reg <= oe_reg;
          end
        endcase
      end
    end
  end

  // Open-drain drive: level is always low, only the enable moves
  assign sda_out   = out_reg;
  assign sda_oe    = oe_reg;
  assign prog_busy = busy_reg;

endmodule // eep_slave

// ===== eep_checker.sv
// Port checker for the two-wire EEPROM slave
`timescale 1ns/10ps
module eep_checker #(
  parameter WRITE_CYCLES = 200
) (
  // Clock and reset
  input logic sys_clk,
  input logic nrst,
  // Link pins
  input logic scl_in,
  input logic sda_in,
  input logic sda_out,
  input logic sda_oe,
  // Straps and status
  input logic chip_select_bit0,
  input logic chip_select_bit1,
  input logic chip_select_bit2,
  input logic write_protect,
  input logic prog_busy
);
  logic [31:0] busy_cnt_reg;
  logic [3:0]  scl_hi_cnt_reg;

  // Length of the running program cycle, cleared when idle
  always @(posedge sys_clk or negedge nrst)
    if (!nrst)
      busy_cnt_reg <= 32'h0;
    else
      busy_cnt_reg <= prog_busy ? busy_cnt_reg + 32'h1 : 32'h0;

  // Run of clock-high samples, saturating so long idle stays counted
  always @(posedge sys_clk or negedge nrst)
    if (!nrst)
      scl_hi_cnt_reg <= 4'h0;
    else if (!scl_in)
      scl_hi_cnt_reg <= 4'h0;
    else if (scl_hi_cnt_reg != 4'hf)
      scl_hi_cnt_reg <= scl_hi_cnt_reg + 4'h1;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_drain_only: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  a_busy_quiet: assert property (prog_busy |-> !sda_oe)
    else $error("ack while programming");
  a_prog_bound: assert property (busy_cnt_reg <= WRITE_CYCLES)
    else $error("program cycle too long");
  a_prog_full: assert property ($fell(prog_busy) |-> busy_cnt_reg >= WRITE_CYCLES)
    else $error("program cycle cut short");
  a_wp_block: assert property ($rose(prog_busy) |-> !$past(write_protect, 8))
    else $error("program under protect");
  // Sync lag puts a data change a few cycles after a clock fall
  a_oe_after_fall: assert property ($changed(sda_oe) |-> !$past(scl_in, 3) || !$past(scl_in, 5))
    else $error("data changed away from clock low");
  a_oe_holds: assert property ($changed(sda_oe) |=> $stable(sda_oe) [*6])
    else $error("data not held for a bit time");
  a_idle_release: assert property (scl_in && scl_hi_cnt_reg >= 4'h8 |-> !sda_oe)
    else $error("data held low while idle");

  c_program: cover property ($fell(prog_busy));
  c_ack: cover property ($rose(sda_oe));
  c_protect: cover property (write_protect && $fell(sda_oe));
endmodule // eep_checker

// ===== eep_i2c_master.sv
// Behavioural two-wire master driving clock and data
`timescale 1ns/10ps
module eep_i2c_master (
  // Link pins
  output logic       scl,
  output logic       sda_low,
  input  logic       sda,
  // Last byte or acknowledge seen
  output logic [7:0] obs
);
  event got;

  // Clock stands high and data released outside frames
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    obs = 8'h00;
  end
  // One bit of 800 ns: low 600, high 200, so the slave's
  // five-cycle answer after a fall settles before the rise
  task automatic clk_bit(input logic b, output logic s);
    #300 sda_low = !b;
    #300 scl = 1'b1;
    #100 s = sda;
    #100 scl = 1'b0;
  endtask
  // Late release leaves the slave time to drop its ack first
  task automatic start();
    #400 sda_low = 1'b0;
    #200 scl = 1'b1;
    #400 sda_low = 1'b1;
    #400 scl = 1'b0;
  endtask
  task automatic stop();
    #200 sda_low = 1'b1;
    #200 scl = 1'b1;
    #400 sda_low = 1'b0;
    #800;
  endtask
  // Byte out MSB first, ack slot reported as 1 when pulled low
  task automatic send(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], s);
    clk_bit(1'b1, s);
    obs = {7'h00, !s};
    -> got;
  endtask
  // Byte in; ack it only when more are wanted
  task automatic recv(input logic more);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, d[i]);
    clk_bit(!more, s);
    obs = d;
    -> got;
  endtask
endmodule // eep_i2c_master

// ===== tb_top.sv
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/10ps
module tb_top;
  localparam int WC = 200;
  logic        sys_clk, nrst, write_protect;
  logic [2:0]  cs;
  logic [31:0] seed = 32'h0ca7;
  logic [7:0]  mem [256];
  logic [7:0]  obs, ctrl;
  logic [7:0]  exp_q [$];
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  wire         scl, sda_low, sda_oe, sda_out, prog_busy;
  // Pull-up: low while either party pulls
  wire         sda = !(sda_low || sda_oe);

  eep_slave #(.WRITE_CYCLES(WC)) eep_slave_inst (.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bit0(cs[0]), .chip_select_bit1(cs[1]),
    .chip_select_bit2(cs[2]), .write_protect(write_protect), .prog_busy(prog_busy));
  eep_i2c_master eep_i2c_master_inst (.scl(scl), .sda_low(sda_low), .sda(sda), .obs(obs));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = !sys_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  // Each observed byte or ack meets the oldest note
  always @(eep_i2c_master_inst.got)
    chk(exp_q.pop_front(), obs);
  task automatic tx(input logic [7:0] d, input logic a);
    exp_q.push_back({7'h00, a});
    eep_i2c_master_inst.send(d);
  endtask
  // Sequential read; expected bytes from the bench copy
  task automatic rd(input logic [7:0] a, input int n);
    eep_i2c_master_inst.start();
    tx(ctrl, 1'b1);
    tx(a, 1'b1);
    eep_i2c_master_inst.start();
    tx(ctrl | 8'h01, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back(mem[8'(a + i)]);
      eep_i2c_master_inst.recv(i < n - 1);
    end
    eep_i2c_master_inst.stop();
  endtask
  // Write n random bytes; protected writes send all n and expect each nacked
  task automatic wr(input logic [7:0] a, input int n, input logic wp);
    logic [7:0] d;
    eep_i2c_master_inst.start();
    tx(ctrl, 1'b1);
    tx(a, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      d = 8'(rnd());
      tx(d, !wp);
      if (!wp)
        mem[{a[7:3], 3'(a[2:0] + i)}] = d;
    end
    eep_i2c_master_inst.stop();
    if (wp)
      chk(8'(prog_busy), 8'h00);
    else
    begin
      eep_i2c_master_inst.start();
      tx(ctrl, 1'b0);
      eep_i2c_master_inst.stop();
      for (int i = 0; i < 2 * WC && prog_busy !== 1'b0; i++)
        @(posedge sys_clk) #2;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Cycle ceiling against a hung link
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      num_errors++;
      stop_test();
    end
  end
  initial
  begin
    logic [7:0] a;
    nrst = 1'b0;
    write_protect = 1'b0;
    cs = 3'h0;
    repeat (6) @(posedge sys_clk);
    #2 nrst = 1'b1;
    cs = 3'(rnd());
    ctrl = {4'ha, cs, 1'b0};
    repeat (8) @(posedge sys_clk);
    #2;
    a = 8'(rnd());
    wr(a, 1, 1'b0);
    rd(a, 1);
    a = 8'(rnd());
    wr(a, 10, 1'b0);
    rd({a[7:3], 3'h0}, 8);
    @(posedge sys_clk);
    #2 write_protect = 1'b1;
    wr(a, 1, 1'b1);
    rd({a[7:3], 3'h0}, 8);
    @(posedge sys_clk);
    #2 write_protect = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      eep_i2c_master_inst.start();
      tx(ctrl ^ (8'h02 << i), 1'b0);
      eep_i2c_master_inst.stop();
    end
    stop_test();
  end
endmodule // tb_top

bind eep_slave eep_checker #(.WRITE_CYCLES(WRITE_CYCLES)) eep_checker_inst (.sys_clk(sys_clk), .nrst(nrst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bit0(chip_select_bit0),
  .chip_select_bit1(chip_select_bit1), .chip_select_bit2(chip_select_bit2), .write_protect(write_protect),
  .prog_busy(prog_busy));
